// File: timer16_pwm.sv
// 16-bit free-running timer: compare, capture, waveform mode, low power
// assumes aclk at 40 mhz, axi4-lite master, pins asynchronous to aclk
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

// Contract
// - waveform: matches drive pin one levels
// - waveform: compare-two match reloads fffc
// - high pulse equals compare two minus compare one
// - equal levels give a constant pin
// - period is compare value plus five
// - high-byte write inhibits match until low
// - waveform mode never sets match flags
// - waveform compare-two match sets capture flag one
// - waveform: capture one off, two works
// - waveform overrides single-pulse mode
// - wait: timer runs, interrupt wakes
// - halt freezes counter, resumes when cpu_halt drops
// - halt capture edge arms, fires on exit
// - one request line, gated, no halt wake
// - bit 7 enables capture interrupts
// - bit 6 enables match interrupts
// - bit 5 enables rollover interrupt
// - bit 4 forces level two pin two outside waveform mode
// - bit 3 forces level one pin one outside waveform mode
// - control register rw, reset 00h
// - three control, six 16-bit register pairs
// - waveform compares reload at period end
// - tick source: div4, div2, div8, external
// - pin enable only routes the pin
module timer16_pwm
    import timer16_pkg::*;
#(
    parameter int  ADDR_W      = 8,
    parameter bit  HAS_EXT_CLK = 1'b1
) (
    input  wire logic              aclk,               // clock
    input  wire logic              aresetn,            // sync reset
    input  wire logic [ADDR_W-1:0] awaddr,             // write address
    input  wire logic              awvalid,            // write addr valid
    output logic                   awready,            // write addr ready
    input  wire logic [31:0]       wdata,              // write data
    input  wire logic [3:0]        wstrb,              // byte enables
    input  wire logic              wvalid,             // write data valid
    output logic                   wready,             // write data ready
    output logic [1:0]             bresp,              // write response
    output logic                   bvalid,             // response valid
    input  wire logic              bready,             // response ready
    input  wire logic [ADDR_W-1:0] araddr,             // read address
    input  wire logic              arvalid,            // read addr valid
    output logic                   arready,            // read addr ready
    output logic [31:0]            rdata,              // read data
    output logic [1:0]             rresp,              // read response
    output logic                   rvalid,             // read valid
    input  wire logic              rready,             // read ready
    input  wire logic              capture_pin_one,    // capture edge in
    input  wire logic              capture_pin_two,    // capture edge in
    input  wire logic              ext_clk_pin,        // external tick
    input  wire logic              cpu_wait,           // cpu in wait
    input  wire logic              cpu_halt,           // cpu in halt
    input  wire logic              irq_mask,           // cpu mask, high masks
    output logic                   wave_out_pin_one,   // pin one level
    output logic                   wave_out_sel_one,   // pin one owned
    output logic                   wave_out_pin_two,   // pin two level
    output logic                   wave_out_sel_two,   // pin two owned
    output logic                   timer_irq,          // interrupt request
    output logic                   wake_from_wait      // wait exit request
);

    // ****************************************
    // state
    // ****************************************
    irq_out_ctrl_t   ctrl_reg;
    mode_ctrl_t      mode_reg;
    flags_t          flag_reg, flag_next, arm_reg, clr;
    logic            tdis_reg;
    logic [15:0]     cnt_reg, cnt_next;
    logic [15:0]     prog1_reg, prog2_reg, act1_reg, act2_reg;
    logic [15:0]     cap1_reg, cap2_reg;
    logic [1:0]      inh_reg;
    logic [2:0]      pre_reg;
    logic            out1_reg, out2_reg;
    logic [2:0]      s1_reg, s2_reg, s3_reg, filt_reg;
    logic [1:0]      harm_reg;
    logic            halt_d_reg;
    logic            aw_full_reg, w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]     w_data_reg;
    logic [3:0]      w_strb_reg;

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    wire [2:0] pins    = {ext_clk_pin, capture_pin_two, capture_pin_one};
    wire [2:0] settle  = ~(s2_reg ^ s3_reg) & (s3_reg ^ filt_reg);
    wire [2:0] rise    = settle & s3_reg;
    wire [2:0] fall    = settle & ~s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg   <= 3'h0;
            s2_reg   <= 3'h0;
            s3_reg   <= 3'h0;
            filt_reg <= 3'h0;
        end else begin
            s1_reg   <= pins;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_reg ^ settle;
        end
    end

    // ****************************************
    // mode and tick source
    // ****************************************
    wire pwm      = mode_reg.wave_mode;
    wire halted   = cpu_halt;
    wire run      = ~halted & ~tdis_reg;
    wire [1:0] src = mode_reg.tick_source_select;
    wire [2:0] pmask = (src == SRC_DIV2) ? MASK_DIV2 :
                       (src == SRC_DIV8) ? MASK_DIV8 : MASK_DIV4;
    wire pre_tick = (pre_reg & pmask) == pmask;
    wire ext_edge = mode_reg.ext_clk_edge ? rise[2] : fall[2];
    wire tick     = (src == SRC_EXT) ? (HAS_EXT_CLK & ext_edge)
                                     : pre_tick;
    wire step     = run & tick;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            pre_reg <= 3'h0;
        else if (run)
            pre_reg <= pre_reg + 3'h1;
    end

    // ****************************************
    // bus decode
    // ****************************************
    wire wr_fire = aw_full_reg & w_full_reg & ~bvalid;
    wire wr_en   = wr_fire & w_strb_reg[0];
    wire rd_fire = arvalid & arready;
    wire [7:0] wa = 8'(aw_addr_reg);
    wire [7:0] ra = 8'(araddr);
    wire [7:0] wb = w_data_reg[7:0];

    wire w_ctrl  = wr_en & (wa == OFF_IRQ_OUT_CTRL);
    wire w_mode  = wr_en & (wa == OFF_MODE_CTRL);
    wire w_flags = wr_en & (wa == OFF_FLAGS);
    wire w_c1h   = wr_en & (wa == OFF_CMP1_HI);
    wire w_c1l   = wr_en & (wa == OFF_CMP1_LO);
    wire w_c2h   = wr_en & (wa == OFF_CMP2_HI);
    wire w_c2l   = wr_en & (wa == OFF_CMP2_LO);
    wire w_cntl  = wr_en & (wa == OFF_CNT_LO);

    // low-byte accesses, read or write, finish a flag clear
    wire a_c1l  = (wr_fire & (wa == OFF_CMP1_LO)) | (rd_fire & (ra == OFF_CMP1_LO));
    wire a_c2l  = (wr_fire & (wa == OFF_CMP2_LO)) | (rd_fire & (ra == OFF_CMP2_LO));
    wire a_cp1l = (wr_fire & (wa == OFF_CAP1_LO)) | (rd_fire & (ra == OFF_CAP1_LO));
    wire a_cp2l = (wr_fire & (wa == OFF_CAP2_LO)) | (rd_fire & (ra == OFF_CAP2_LO));
    wire a_cntl = (wr_fire & (wa == OFF_CNT_LO)) | (rd_fire & (ra == OFF_CNT_LO));
    wire r_flags = rd_fire & (ra == OFF_FLAGS);

    wire w_map = (wa <= OFF_CAP2_LO) & (wa[1:0] == 2'b00);
    wire r_map = (ra <= OFF_CAP2_LO) & (ra[1:0] == 2'b00);

    // ****************************************
    // counter, matches, captures
    // ****************************************
    wire m1   = step & (cnt_reg == act1_reg) & ~inh_reg[0];
    wire m2   = step & (cnt_reg == act2_reg) & ~inh_reg[1];
    wire wrap = step & ~(pwm & m2) & (cnt_reg == CNT_MAX);
    wire hexit = halt_d_reg & ~halted;
    wire e1    = ctrl_reg.capture_edge_one ? rise[0] : fall[0];
    wire e2    = mode_reg.capture_edge_two ? rise[1] : fall[1];
    wire ev1   = e1 & ~pwm;
    wire ev2   = e2;
    wire cap1  = (ev1 & ~halted) | (hexit & harm_reg[0]);
    wire cap2  = (ev2 & ~halted) | (hexit & harm_reg[1]);

    always_comb begin
        if (w_cntl)
            cnt_next = CNT_RESET;
        else if (step && pwm && m2)
            cnt_next = PWM_RELOAD;
        else if (step)
            cnt_next = cnt_reg + 16'h1;
        else
            cnt_next = cnt_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg    <= CNT_RESET;
            halt_d_reg <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            halt_d_reg <= halted;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            harm_reg <= 2'b00;
        else if (hexit)
            harm_reg <= 2'b00;
        else if (halted)
            harm_reg <= harm_reg | {ev2, ev1};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap1_reg <= 16'h0;
            cap2_reg <= 16'h0;
        end else begin
            if (cap1)
                cap1_reg <= cnt_reg;
            if (cap2)
                cap2_reg <= cnt_reg;
        end
    end

    // ****************************************
    // compare values and double buffering
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog1_reg <= CMP_RESET;
            prog2_reg <= CMP_RESET;
            inh_reg   <= 2'b00;
        end else begin
            if (w_c1h) prog1_reg[15:8] <= wb;
            if (w_c1l) prog1_reg[7:0]  <= wb;
            if (w_c2h) prog2_reg[15:8] <= wb;
            if (w_c2l) prog2_reg[7:0]  <= wb;
            inh_reg[0] <= (inh_reg[0] | w_c1h) & ~w_c1l;
            inh_reg[1] <= (inh_reg[1] | w_c2h) & ~w_c2l;
        end
    end

    // in waveform mode the working copies follow only at period end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act1_reg <= CMP_RESET;
            act2_reg <= CMP_RESET;
        end else if (!pwm || m2) begin
            act1_reg <= prog1_reg;
            act2_reg <= prog2_reg;
        end
    end

    // ****************************************
    // output levels
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out1_reg <= 1'b0;
            out2_reg <= 1'b0;
        end else if (pwm) begin
            if (m2)
                out1_reg <= ctrl_reg.level_after_two;
            else if (m1)
                out1_reg <= ctrl_reg.level_after_one;
        end else begin
            if (m1 || ctrl_reg.force_level_one)
                out1_reg <= ctrl_reg.level_after_one;
            if (m2 || ctrl_reg.force_level_two)
                out2_reg <= ctrl_reg.level_after_two;
        end
    end

    always_comb begin
        wave_out_pin_one = out1_reg;
        wave_out_pin_two = out2_reg;
        wave_out_sel_one = mode_reg.out_pin_enable_one & ~tdis_reg;
        wave_out_sel_two = mode_reg.out_pin_enable_two & ~tdis_reg;
    end

    // ****************************************
    // event flags, two-step clear, set wins
    // ****************************************
    flags_t set;
    always_comb begin
        set.capture_flag_one = cap1 | (pwm & m2);
        set.match_flag_one   = m1 & ~pwm;
        set.rollover_flag    = wrap;
        set.capture_flag_two = cap2;
        set.match_flag_two   = m2 & ~pwm;
        clr.capture_flag_one = a_cp1l & arm_reg.capture_flag_one;
        clr.match_flag_one   = a_c1l & arm_reg.match_flag_one;
        clr.rollover_flag    = a_cntl & arm_reg.rollover_flag;
        clr.capture_flag_two = a_cp2l & arm_reg.capture_flag_two;
        clr.match_flag_two   = a_c2l & arm_reg.match_flag_two;
        flag_next = (flag_reg & ~clr) | set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= '0;
            arm_reg  <= '0;
        end else begin
            flag_reg <= flag_next;
            arm_reg  <= r_flags ? flag_reg : (arm_reg & ~clr);
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    wire cap_req = ctrl_reg.capture_irq_enable &
                   (flag_reg.capture_flag_one | flag_reg.capture_flag_two);
    wire mat_req = ctrl_reg.match_irq_enable &
                   (flag_reg.match_flag_one | flag_reg.match_flag_two);
    wire rol_req = ctrl_reg.rollover_irq_enable & flag_reg.rollover_flag;
    wire any_req = cap_req | mat_req | rol_req;

    always_comb begin
        timer_irq      = any_req & ~irq_mask;
        wake_from_wait = timer_irq & cpu_wait;
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= irq_out_ctrl_t'(CTRL_RESET);
            mode_reg <= mode_ctrl_t'(CTRL_RESET);
            tdis_reg <= 1'b0;
        end else begin
            if (w_ctrl)
                ctrl_reg <= irq_out_ctrl_t'(wb);
            if (w_mode)
                mode_reg <= mode_ctrl_t'(wb);
            if (w_flags)
                tdis_reg <= wb[2];
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    always_comb begin
        awready = ~aw_full_reg & ~bvalid;
        wready  = ~w_full_reg & ~bvalid;
        arready = ~rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= w_map ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    logic [7:0] rd_byte;
    always_comb begin
        unique case (ra)
            OFF_IRQ_OUT_CTRL: rd_byte = ctrl_reg;
            OFF_MODE_CTRL:    rd_byte = mode_reg;
            OFF_FLAGS:        rd_byte = {flag_reg, tdis_reg, 2'b00};
            OFF_CMP1_HI:      rd_byte = prog1_reg[15:8];
            OFF_CMP1_LO:      rd_byte = prog1_reg[7:0];
            OFF_CMP2_HI:      rd_byte = prog2_reg[15:8];
            OFF_CMP2_LO:      rd_byte = prog2_reg[7:0];
            OFF_CNT_HI,
            OFF_ALT_HI:       rd_byte = cnt_reg[15:8];
            OFF_CNT_LO,
            OFF_ALT_LO:       rd_byte = cnt_reg[7:0];
            OFF_CAP1_HI:      rd_byte = cap1_reg[15:8];
            OFF_CAP1_LO:      rd_byte = cap1_reg[7:0];
            OFF_CAP2_HI:      rd_byte = cap2_reg[15:8];
            OFF_CAP2_LO:      rd_byte = cap2_reg[7:0];
            default:          rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h0, rd_byte};
            rresp  <= r_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : timer16_pwm

// File: timer16_pkg.sv
// constants, offsets and field layouts of the 16-bit timer
// assumes a 32-bit axi4-lite register bus, one register per word
package timer16_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_IRQ_OUT_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE_CTRL    = 8'h04;
    localparam logic [7:0] OFF_FLAGS        = 8'h08;
    localparam logic [7:0] OFF_CMP1_HI      = 8'h0c;
    localparam logic [7:0] OFF_CMP1_LO      = 8'h10;
    localparam logic [7:0] OFF_CMP2_HI      = 8'h14;
    localparam logic [7:0] OFF_CMP2_LO      = 8'h18;
    localparam logic [7:0] OFF_CNT_HI       = 8'h1c;
    localparam logic [7:0] OFF_CNT_LO       = 8'h20;
    localparam logic [7:0] OFF_ALT_HI       = 8'h24;
    localparam logic [7:0] OFF_ALT_LO       = 8'h28;
    localparam logic [7:0] OFF_CAP1_HI      = 8'h2c;
    localparam logic [7:0] OFF_CAP1_LO      = 8'h30;
    localparam logic [7:0] OFF_CAP2_HI      = 8'h34;
    localparam logic [7:0] OFF_CAP2_LO      = 8'h38;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] CMP_RESET    = 16'h8000;
    localparam logic [15:0] CNT_RESET    = 16'hfffc;
    localparam logic [15:0] PWM_RELOAD   = 16'hfffc;
    localparam logic [15:0] CNT_MAX      = 16'hffff;
    localparam logic [1:0]  SRC_DIV4     = 2'b00;
    localparam logic [1:0]  SRC_DIV2     = 2'b01;
    localparam logic [1:0]  SRC_DIV8     = 2'b10;
    localparam logic [1:0]  SRC_EXT      = 2'b11;
    localparam logic [2:0]  MASK_DIV4    = 3'h3;
    localparam logic [2:0]  MASK_DIV2    = 3'h1;
    localparam logic [2:0]  MASK_DIV8    = 3'h7;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    // ****************************************
    // register layouts, msb first
    // ****************************************
    typedef struct packed {
        logic capture_irq_enable;   // bit 7
        logic match_irq_enable;     // bit 6
        logic rollover_irq_enable;  // bit 5
        logic force_level_two;      // bit 4
        logic force_level_one;      // bit 3
        logic level_after_two;      // bit 2
        logic capture_edge_one;     // bit 1
        logic level_after_one;      // bit 0
    } irq_out_ctrl_t;

    typedef struct packed {
        logic       out_pin_enable_one;
        logic       out_pin_enable_two;
        logic       single_pulse_select;
        logic       wave_mode;
        logic [1:0] tick_source_select;
        logic       capture_edge_two;
        logic       ext_clk_edge;
    } mode_ctrl_t;

    typedef struct packed {
        logic capture_flag_one;
        logic match_flag_one;
        logic rollover_flag;
        logic capture_flag_two;
        logic match_flag_two;
    } flags_t;

endpackage : timer16_pkg

// File: timer16_props.sv
// checker: bus handshake, interrupt gating and reset relations
// assumes bind onto timer16_pwm, single aclk domain
`timescale 1ns/1ps
module timer16_props (
    input wire logic        aclk,             // clock
    input wire logic        aresetn,          // reset
    input wire logic        awvalid,          // aw valid
    input wire logic        awready,          // aw ready
    input wire logic        wvalid,           // w valid
    input wire logic        wready,           // w ready
    input wire logic [1:0]  bresp,            // b resp
    input wire logic        bvalid,           // b valid
    input wire logic        bready,           // b ready
    input wire logic        arvalid,          // ar valid
    input wire logic        arready,          // ar ready
    input wire logic [31:0] rdata,            // r data
    input wire logic        rvalid,           // r valid
    input wire logic        rready,           // r ready
    input wire logic        cpu_wait,         // wait state
    input wire logic        irq_mask,         // cpu mask
    input wire logic        wave_out_pin_one, // pin one
    input wire logic        timer_irq,        // request
    input wire logic        wake_from_wait    // wait exit
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr; awvalid && awready && wvalid && wready; endsequence
    sequence s_rd; arvalid && arready; endsequence
    property p_mask; irq_mask |-> !timer_irq; endproperty
    a_mask: assert property (p_mask) else $error("request while masked");
    property p_wake; wake_from_wait == (timer_irq && cpu_wait); endproperty
    a_wake: assert property (p_wake) else $error("wait exit wrong");
    property p_bans; s_wr |=> ##1 bvalid; endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_bblock; bvalid |-> !awready && !wready; endproperty
    a_bblock: assert property (p_bblock) else $error("taken during answer");
    property p_rans; s_rd |=> rvalid; endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rhi; rvalid |-> rdata[31:8] == 24'h0; endproperty
    a_rhi: assert property (p_rhi) else $error("upper read bits set");
    property p_rst; $rose(aresetn) |-> !timer_irq && !wave_out_pin_one; endproperty
    a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule : timer16_props
bind timer16_pwm timer16_props u_props (.*);

// File: timer16_pins.sv
// edge sources on the timer pins
// assumes aclk from the bench; pins change just after an edge
`timescale 1ns/1ps
module timer16_pins (
    input  wire logic aclk,            // clock
    input  wire logic cap_two_req,     // wanted level, pin two
    output logic      capture_pin_one, // quiet capture one
    output logic      capture_pin_two, // capture two source
    output logic      ext_clk_pin      // free-running tick
);
    initial begin
        capture_pin_one = 1'b0;
        capture_pin_two = 1'b0;
        ext_clk_pin     = 1'b0;
    end
    always @(posedge aclk) begin
        capture_pin_two <= cap_two_req;
        ext_clk_pin     <= ~ext_clk_pin;
    end
endmodule : timer16_pins

// File: timer16_pwm_test.sv
// self-checking bench for the 16-bit timer
// assumes timer16_pwm, its checker and timer16_pins
`timescale 1ns/1ps
module timer16_pwm_test;
    import timer16_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cpu_wait, cpu_halt, irq_mask;
    logic        capture_pin_one, capture_pin_two, ext_clk_pin, cap_two_req, timer_irq;
    logic        wave_out_pin_one, wave_out_sel_one, wave_out_pin_two, wave_out_sel_two;
    logic        wake_from_wait;
    logic [7:0]  awaddr, araddr, d, e;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    time         t0, t1, t2;
    timer16_pwm dut_u (.*);
    timer16_pins pin_u (.aclk(aclk), .cap_two_req(cap_two_req),
        .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
        .ext_clk_pin(ext_clk_pin));
    // ****************************************
    // support
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] s);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata[7:0];
        s = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_ctrl();
        rd(OFF_IRQ_OUT_CTRL, d, r);
        chk(d, CTRL_RESET);
        wr(OFF_IRQ_OUT_CTRL, 8'h46);
        rd(OFF_IRQ_OUT_CTRL, d, r);
        chk(d, 8'h46);
        rd(OFF_CMP1_HI, d, r);
        chk(d, CMP_RESET[15:8]);
        rd(8'h3c, d, r);
        chk(r, RESP_SLVERR);
        wr(8'h3c, 8'h00);
        chk(r, RESP_SLVERR);
        wr(OFF_IRQ_OUT_CTRL, 8'h00);
        chk(r, RESP_OKAY);
    endtask : t_ctrl
    task automatic t_roll();
        wr(OFF_IRQ_OUT_CTRL, 8'h20);
        chk(timer_irq, 1'b1);
        irq_mask <= 1'b1;
        cpu_wait <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(timer_irq, 1'b0);
        irq_mask <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(wake_from_wait, 1'b1);
        cpu_wait <= 1'b0;
        rd(OFF_FLAGS, d, r);
        chk(d, 8'h20);
        rd(OFF_CNT_LO, d, r);
        @(posedge aclk);
        chk(timer_irq, 1'b0);
        wr(OFF_IRQ_OUT_CTRL, 8'h00);
    endtask : t_roll
    task automatic t_halt();
        wr(OFF_MODE_CTRL, 8'hc6);
        cpu_halt <= 1'b1;
        rd(OFF_CNT_LO, d, r);
        cap_two_req <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(OFF_CNT_LO, e, r);
        chk(e, d);
        cpu_halt <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(OFF_FLAGS, e, r);
        chk(e[4], 1'b1);
        rd(OFF_CAP2_LO, e, r);
        chk(e, d);
        wr(OFF_IRQ_OUT_CTRL, 8'h1d);
        chk({wave_out_pin_two, wave_out_sel_two, wave_out_pin_one, wave_out_sel_one}, 4'hf);
    endtask : t_halt
    task automatic t_pwm();
        logic [7:0] a[9] = '{OFF_FLAGS, OFF_CMP1_HI, OFF_CMP1_LO, OFF_CMP2_HI,
            OFF_CMP2_LO, OFF_IRQ_OUT_CTRL, OFF_MODE_CTRL, OFF_CNT_LO, OFF_FLAGS};
        logic [7:0] v[9] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h0a, 8'h01, 8'hb4, 8'h00, 8'h00};
        foreach (a[i]) wr(a[i], v[i]);
        @(posedge wave_out_pin_one);
        t0 = $time;
        @(negedge wave_out_pin_one);
        t1 = $time;
        @(posedge wave_out_pin_one);
        t2 = $time;
        chk(32'((t1 - t0) / 25), 32'd12);
        chk(32'((t2 - t0) / 25), 32'd30);
        chk(wave_out_sel_one, 1'b1);
        rd(OFF_FLAGS, d, r);
        chk(d & 8'hc8, 8'h80);
        wr(OFF_IRQ_OUT_CTRL, 8'h05);
        repeat (40) @(posedge aclk);
        e = 8'h00;
        repeat (40) begin
            @(posedge aclk);
            if (wave_out_pin_one !== 1'b1) e = 8'h01;
        end
        chk(e, 8'h00);
    endtask : t_pwm
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_wait, cpu_halt} = '0;
        {irq_mask, cap_two_req, awaddr, araddr, wdata} = '0;
        wstrb = 4'h1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_ctrl();
        t_roll();
        t_halt();
        t_pwm();
        end_sim();
    end
endmodule : timer16_pwm_test
